// ### src/dtp_pkg.sv
package dtp_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_UP_COUNT   = 4'h0;
    localparam logic [3:0] ADDR_UP_MODE    = 4'h1;
    localparam logic [3:0] ADDR_POWER_CTRL = 4'h2;
    localparam logic [3:0] ADDR_DOWN_LOW   = 4'h3;
    localparam logic [3:0] ADDR_HIGH_BITS  = 4'h4;
    localparam logic [3:0] ADDR_DOWN_CTRLA = 4'h5;
    localparam logic [3:0] ADDR_DOWN_CTRLB = 4'h6;
    localparam logic [3:0] ADDR_DUTY_LOW   = 4'h7;
    localparam logic [3:0] ADDR_TONE_CTRL  = 4'h8;
    localparam logic [3:0] ADDR_IRQ_FLAG   = 4'h9;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hA;
    localparam logic [3:0] ADDR_PRESC_VAL  = 4'hB;
    // Up-counter mode register fields
    localparam int UP_LOW_CLK_BIT = 7;
    localparam int UP_SRC_BIT     = 5;
    localparam int UP_EDGE_BIT    = 4;
    localparam int UP_ASSIGN_BIT  = 3;
    // Power control fields
    localparam int GLOBAL_IRQ_BIT = 7;
    localparam int UP_RUN_BIT     = 0;
    // Down-counter control A fields
    localparam int PWM_OEN_BIT    = 7;
    localparam int PWM_POL_BIT    = 6;
    localparam int ONE_SHOT_BIT   = 2;
    localparam int RELOAD_BIT     = 1;
    localparam int DOWN_RUN_BIT   = 0;
    // Down-counter control B fields
    localparam int DOWN_SRC_BIT   = 5;
    localparam int DOWN_EDGE_BIT  = 4;
    localparam int DOWN_PSEN_BIT  = 3;
    // High bits register fields
    localparam int RELOAD_HI_LSB  = 4;
    localparam int DUTY_HI_LSB    = 0;
    // Tone control fields
    localparam int TONE_EN_BIT    = 7;
    localparam int TONE_SRC_BIT   = 3;
    // Interrupt flag positions
    localparam int UP_FLAG_BIT    = 0;
    localparam int DOWN_FLAG_BIT  = 3;
    // Reset values and counter constants
    localparam logic [7:0] UP_MODE_RST  = 8'h08;
    localparam logic [7:0] CTRLB_RST    = 8'h08;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [9:0] ZERO10       = 10'h000;
    localparam logic [9:0] FREE_RESTART = 10'h0FF;
    localparam logic [9:0] ONE10        = 10'h001;
endpackage : dtp_pkg

// ### src/dtp_prescaler.sv
`timescale 1ns/1ps
// Free divider: ratio 2^(sel+1), pulse on wrap
module dtp_prescaler (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] ratio_sel_i,
    output logic            tick_o,
    output logic [7:0]      value_o
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] last_val;

    // Wrap value 1,3..255 (ratio 2,4..256) in ascending code order
    always_comb begin
        last_val = 8'((9'h002 << ratio_sel_i) - 9'h001);
        count_next = count_reg;
        tick_o = 1'b0;
        if (clear_i) begin
            count_next = dtp_pkg::ZERO8;
        end else if (tick_i) begin
            if (count_reg >= last_val) begin
                count_next = dtp_pkg::ZERO8;
                tick_o = 1'b1;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    // Count register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            count_reg <= dtp_pkg::ZERO8;
        end else begin
            count_reg <= count_next;
        end
    end

    assign value_o = count_reg;
endmodule : dtp_prescaler

// ### src/dtp_timer.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module dtp_timer (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic       instr_tick_i,
    input  wire logic       low_clock_i,
    input  wire logic       external_count_input_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    output logic            irq_o,
    output logic            pulse_width_output_a_o,
    output logic            pulse_oe_o,
    output logic            tone_output_o,
    output logic            tone_oe_o
);
    typedef enum logic [1:0] {
        DTP_IDLE  = 2'b00,
        DTP_COUNT = 2'b01,
        DTP_DONE  = 2'b10
    } dtp_state_type;

    logic [7:0] up_count_reg, up_count_next, up_mode_reg, up_mode_next;
    logic [7:0] power_reg, power_next, ctrla_reg, ctrla_next, ctrlb_reg, ctrlb_next;
    logic [7:0] high_reg, high_next, duty_lo_reg, duty_lo_next, tone_reg, tone_next;
    logic [7:0] flag_reg, flag_next, ien_reg, ien_next, rdata_reg, rdata_next;
    logic [9:0] down_reg, down_next, reload_reg, reload_next, duty_reg, duty_next;
    logic [9:0] phase_reg, phase_next;
    logic       pin_reg, low_reg, tone_reg_q, tone_q_next;
    logic       pwm_reg, pwm_next;
    dtp_state_type st_reg, st_next;
    logic       up_src_tick, up_tick, down_src_tick, down_tick, up_clear, bz_src;
    logic       sh_tick, d_ptick, bz_tick, underflow;
    logic [7:0] d_pval;
    logic [7:0] sh_val;

    // Edge picker for pin or low clock, shared by both counters
    function automatic logic edge_hit(input logic prev, input logic cur, input logic fall);
        edge_hit = fall ? (prev & ~cur) : (~prev & cur);
    endfunction : edge_hit

    function automatic logic wr_at(input logic [3:0] a, input logic [3:0] off, input logic w);
        wr_at = w && (a == off);
    endfunction : wr_at

    // Clock source selects
    always_comb begin
        if (!up_mode_reg[dtp_pkg::UP_SRC_BIT]) begin
            up_src_tick = instr_tick_i;
        end else if (up_mode_reg[dtp_pkg::UP_LOW_CLK_BIT]) begin
            up_src_tick = edge_hit(low_reg, low_clock_i,
                                   up_mode_reg[dtp_pkg::UP_EDGE_BIT]);
        end else begin
            up_src_tick = edge_hit(pin_reg, external_count_input_i,
                                   up_mode_reg[dtp_pkg::UP_EDGE_BIT]);
        end
        down_src_tick = ctrlb_reg[dtp_pkg::DOWN_SRC_BIT] ?
            edge_hit(pin_reg, external_count_input_i,
                     ctrlb_reg[dtp_pkg::DOWN_EDGE_BIT]) : instr_tick_i;
    end

    // Writing 0 to the assign bit clears the shared prescaler
    assign up_clear = wr_at(addr_i, dtp_pkg::ADDR_UP_MODE, wr_i) &&
                      !wdata_i[dtp_pkg::UP_ASSIGN_BIT];

    dtp_prescaler u_shared (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .clear_i     (up_clear),
        .tick_i      (up_src_tick),
        .ratio_sel_i (up_mode_reg[2:0]),
        .tick_o      (sh_tick),
        .value_o     (sh_val)
    );

    dtp_prescaler u_down (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .clear_i     (1'b0),
        .tick_i      (down_src_tick),
        .ratio_sel_i (ctrlb_reg[2:0]),
        .tick_o      (d_ptick),
        .value_o     (d_pval)
    );

    assign up_tick = up_mode_reg[dtp_pkg::UP_ASSIGN_BIT] ? up_src_tick : sh_tick;
    assign down_tick = ctrlb_reg[dtp_pkg::DOWN_PSEN_BIT] ? down_src_tick : d_ptick;
    assign underflow = (st_reg == DTP_COUNT) && ctrla_reg[dtp_pkg::DOWN_RUN_BIT] &&
                       down_tick && (down_reg == dtp_pkg::ZERO10);

    // Register file, counters and flags
    always_comb begin
        up_mode_next = up_mode_reg;
        power_next = power_reg;
        ctrla_next = ctrla_reg;
        ctrlb_next = ctrlb_reg;
        high_next = high_reg;
        duty_lo_next = duty_lo_reg;
        tone_next = tone_reg;
        ien_next = ien_reg;
        reload_next = reload_reg;
        flag_next = flag_reg;
        up_count_next = up_count_reg;
        down_next = down_reg;
        duty_next = duty_reg;
        st_next = st_reg;
        // Counting
        if (power_reg[dtp_pkg::UP_RUN_BIT] && up_tick) begin
            up_count_next = up_count_reg + 8'h01;
        end
        unique case (st_reg)
            DTP_IDLE: begin
                if (ctrla_reg[dtp_pkg::DOWN_RUN_BIT]) begin
                    st_next = DTP_COUNT;
                end
            end
            DTP_COUNT: begin
                if (!ctrla_reg[dtp_pkg::DOWN_RUN_BIT]) begin
                    st_next = DTP_IDLE;
                end else if (underflow) begin
                    duty_next = {high_reg[dtp_pkg::DUTY_HI_LSB +: 2], duty_lo_reg};
                    if (ctrla_reg[dtp_pkg::ONE_SHOT_BIT]) begin
                        st_next = DTP_DONE;
                    end else begin
                        down_next = ctrla_reg[dtp_pkg::RELOAD_BIT] ?
                                    reload_reg : dtp_pkg::FREE_RESTART;
                    end
                end else if (down_tick) begin
                    down_next = down_reg - dtp_pkg::ONE10;
                end
            end
            DTP_DONE: begin
                if (!ctrla_reg[dtp_pkg::DOWN_RUN_BIT]) begin
                    st_next = DTP_IDLE;
                end
            end
        endcase
        // Writes, flag clears lose to hardware sets below
        if (wr_i) begin
            unique case (addr_i)
                dtp_pkg::ADDR_UP_COUNT:   up_count_next = wdata_i;
                dtp_pkg::ADDR_UP_MODE:    up_mode_next = wdata_i;
                dtp_pkg::ADDR_POWER_CTRL: power_next = wdata_i;
                dtp_pkg::ADDR_DOWN_LOW: begin
                    reload_next = {high_reg[dtp_pkg::RELOAD_HI_LSB +: 2], wdata_i};
                    down_next = {high_reg[dtp_pkg::RELOAD_HI_LSB +: 2], wdata_i};
                    if (st_reg == DTP_DONE) begin
                        st_next = DTP_IDLE;
                    end
                end
                dtp_pkg::ADDR_HIGH_BITS:  high_next = wdata_i;
                dtp_pkg::ADDR_DOWN_CTRLA: ctrla_next = wdata_i;
                dtp_pkg::ADDR_DOWN_CTRLB: ctrlb_next = wdata_i;
                dtp_pkg::ADDR_DUTY_LOW:   duty_lo_next = wdata_i;
                dtp_pkg::ADDR_TONE_CTRL:  tone_next = wdata_i;
                dtp_pkg::ADDR_IRQ_FLAG:   flag_next = flag_reg & wdata_i;
                dtp_pkg::ADDR_IRQ_ENABLE: ien_next = wdata_i;
                default: ;
            endcase
        end
        if (power_reg[dtp_pkg::UP_RUN_BIT] && up_tick && (up_count_reg == 8'hFF)) begin
            flag_next[dtp_pkg::UP_FLAG_BIT] = 1'b1;
        end
        if (underflow) begin
            flag_next[dtp_pkg::DOWN_FLAG_BIT] = 1'b1;
        end
    end

    // Read mux, data one cycle after the strobe
    always_comb begin
        rdata_next = dtp_pkg::ZERO8;
        if (rd_i) begin
            unique case (addr_i)
                dtp_pkg::ADDR_UP_COUNT:   rdata_next = up_count_reg;
                dtp_pkg::ADDR_UP_MODE:    rdata_next = up_mode_reg;
                dtp_pkg::ADDR_POWER_CTRL: rdata_next = power_reg;
                dtp_pkg::ADDR_DOWN_LOW:   rdata_next = down_reg[7:0];
                dtp_pkg::ADDR_HIGH_BITS:  rdata_next = {high_reg[7:6], down_reg[9:8],
                                                        high_reg[3:0]};
                dtp_pkg::ADDR_DOWN_CTRLA: rdata_next = ctrla_reg;
                dtp_pkg::ADDR_DOWN_CTRLB: rdata_next = ctrlb_reg;
                dtp_pkg::ADDR_TONE_CTRL:  rdata_next = tone_reg;
                dtp_pkg::ADDR_IRQ_FLAG:   rdata_next = flag_reg;
                dtp_pkg::ADDR_IRQ_ENABLE: rdata_next = ien_reg;
                dtp_pkg::ADDR_PRESC_VAL:  rdata_next = d_pval;
                default:                  rdata_next = dtp_pkg::ZERO8;
            endcase
        end
    end

    // Pulse output: phase counts input clocks from wrap
    always_comb begin
        phase_next = phase_reg;
        pwm_next = pwm_reg;
        if (underflow || st_reg != DTP_COUNT) begin
            phase_next = dtp_pkg::ZERO10;
        end else if (down_tick) begin
            phase_next = phase_reg + dtp_pkg::ONE10;
        end
        pwm_next = (st_reg == DTP_COUNT) && (phase_next < duty_reg);
    end

    // Tone: toggles on the selected source divided by 2^(sel+1)
    assign bz_src = tone_reg[dtp_pkg::TONE_SRC_BIT] ? underflow : d_ptick;
    dtp_prescaler u_tone (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .clear_i     (~tone_reg[dtp_pkg::TONE_EN_BIT]),
        .tick_i      (bz_src),
        .ratio_sel_i (tone_reg[2:0]),
        .tick_o      (bz_tick),
        .value_o     ()
    );
    assign tone_q_next = tone_reg[dtp_pkg::TONE_EN_BIT] ? (tone_reg_q ^ bz_tick) : 1'b0;

    // State registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            up_count_reg <= dtp_pkg::ZERO8;
            up_mode_reg <= dtp_pkg::UP_MODE_RST;
            power_reg <= dtp_pkg::ZERO8;
            ctrla_reg <= dtp_pkg::ZERO8;
            ctrlb_reg <= dtp_pkg::CTRLB_RST;
            high_reg <= dtp_pkg::ZERO8;
            duty_lo_reg <= dtp_pkg::ZERO8;
            tone_reg <= dtp_pkg::ZERO8;
            flag_reg <= dtp_pkg::ZERO8;
            ien_reg <= dtp_pkg::ZERO8;
            rdata_reg <= dtp_pkg::ZERO8;
            down_reg <= dtp_pkg::ZERO10;
            reload_reg <= dtp_pkg::ZERO10;
            duty_reg <= dtp_pkg::ZERO10;
            phase_reg <= dtp_pkg::ZERO10;
            st_reg <= DTP_IDLE;
            pin_reg <= 1'b0;
            low_reg <= 1'b0;
            tone_reg_q <= 1'b0;
            pwm_reg <= 1'b0;
        end else begin
            up_count_reg <= up_count_next;
            up_mode_reg <= up_mode_next;
            power_reg <= power_next;
            ctrla_reg <= ctrla_next;
            ctrlb_reg <= ctrlb_next;
            high_reg <= high_next;
            duty_lo_reg <= duty_lo_next;
            tone_reg <= tone_next;
            flag_reg <= flag_next;
            ien_reg <= ien_next;
            rdata_reg <= rdata_next;
            down_reg <= down_next;
            reload_reg <= reload_next;
            duty_reg <= duty_next;
            phase_reg <= phase_next;
            st_reg <= st_next;
            pin_reg <= external_count_input_i;
            low_reg <= low_clock_i;
            tone_reg_q <= tone_q_next;
            pwm_reg <= pwm_next;
        end
    end

    // Outputs
    assign rdata_o = rdata_reg;
    assign irq_o = power_reg[dtp_pkg::GLOBAL_IRQ_BIT] &&
                   |(flag_reg & ien_reg &
                     ((8'h01 << dtp_pkg::UP_FLAG_BIT) | (8'h01 << dtp_pkg::DOWN_FLAG_BIT)));
    assign pulse_oe_o = ctrla_reg[dtp_pkg::PWM_OEN_BIT];
    assign pulse_width_output_a_o = pwm_reg ^ ctrla_reg[dtp_pkg::PWM_POL_BIT];
    assign tone_oe_o = tone_reg[dtp_pkg::TONE_EN_BIT];
    assign tone_output_o = tone_reg_q;

    // Checks
    up_flag_set_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        power_reg[0] && up_tick && up_count_reg == 8'hFF |=> flag_reg[0])
        else $error("overflow flag not set");
    down_flag_set_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        underflow |=> flag_reg[3])
        else $error("underflow flag not set");
    one_shot_stop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        underflow && ctrla_reg[2] && !(wr_i && addr_i == 4'h3) |=> st_reg == DTP_DONE)
        else $error("one shot did not stop");
    reload_pick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        underflow && !ctrla_reg[2] && !wr_i |=>
        down_reg == ($past(ctrla_reg[1]) ? $past(reload_reg) : 10'h0FF))
        else $error("wrong restart value");
    duty_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        duty_reg == 10'h000 && $stable(duty_reg) |-> !pwm_reg)
        else $error("zero duty asserted output");
    up_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_i && addr_i == 4'h0 |=> up_count_reg == $past(wdata_i))
        else $error("up counter load lost");
    duty_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !underflow |=> duty_reg == $past(duty_reg))
        else $error("duty changed outside wrap");
    irq_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        irq_o |-> power_reg[7] && (flag_reg[0] && ien_reg[0] || flag_reg[3] && ien_reg[3]))
        else $error("irq without cause");
    // A one-shot wrap leaves the count parked at zero in the stop state
    sequence one_shot_wrap_s;
        underflow && ctrla_reg[dtp_pkg::ONE_SHOT_BIT] && !wr_i;
    endsequence
    sequence parked_s;
        st_reg == DTP_DONE && down_reg == dtp_pkg::ZERO10;
    endsequence
    one_shot_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        one_shot_wrap_s |=> parked_s)
        else $error("one shot count not parked");
    up_step_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        power_reg[dtp_pkg::UP_RUN_BIT] && up_tick && !wr_i |=>
        up_count_reg == $past(up_count_reg) + 8'h01)
        else $error("up counter missed a tick");
    reload_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_at(addr_i, dtp_pkg::ADDR_DOWN_LOW, wr_i) |=> reload_reg == down_reg)
        else $error("reload and count differ after write");
    presc_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        up_clear |=> sh_val == dtp_pkg::ZERO8)
        else $error("shared prescaler not cleared");
endmodule : dtp_timer

// ### testbench/dtp_pin_model.sv
`timescale 1ns/1ps
// Far side of the timer: count pin and low-speed oscillator sources
module dtp_pin_model (
    input  wire logic sys_clk_i,
    output logic      count_pin_o,
    output logic      low_clock_o
);
    // Both sources rest low until a scenario moves them
    initial begin
        count_pin_o = 1'b0;
        low_clock_o = 1'b0;
    end

    // Move one source after an edge, then hold it so edges are never too close
    task automatic drive(input logic use_low, input logic level);
        @(posedge sys_clk_i);
        if (use_low) begin
            low_clock_o <= level;
        end else begin
            count_pin_o <= level;
        end
        repeat (3) @(posedge sys_clk_i);
    endtask : drive
endmodule : dtp_pin_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       sys_clk_i;
    logic       srst_i;
    logic       instr_tick_i;
    logic       pin;
    logic       low_clk;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       irq_o;
    logic       pulse_out;
    logic       pulse_oe;
    logic       tone_out;
    logic       tone_oe;
    logic       last;
    int         fail_count;
    int         n_tests;
    int         cycles;
    int         hits;
    int         togs;
    logic [7:0] tone_cfg [3] = '{8'h88, 8'h89, 8'h80};
    logic [7:0] ctrlb_cfg [3] = '{8'h08, 8'h08, 8'h00};
    logic [7:0] togs_exp [3] = '{8'h08, 8'h04, 8'h10};

    dtp_pin_model pins (
        .sys_clk_i   (sys_clk_i),
        .count_pin_o (pin),
        .low_clock_o (low_clk)
    );

    dtp_timer dut (
        .sys_clk_i              (sys_clk_i),
        .srst_i                 (srst_i),
        .instr_tick_i           (instr_tick_i),
        .low_clock_i            (low_clk),
        .external_count_input_i (pin),
        .addr_i                 (addr_i),
        .wdata_i                (wdata_i),
        .wr_i                   (wr_i),
        .rd_i                   (rd_i),
        .rdata_o                (rdata_o),
        .irq_o                  (irq_o),
        .pulse_width_output_a_o (pulse_out),
        .pulse_oe_o             (pulse_oe),
        .tone_output_o          (tone_out),
        .tone_oe_o              (tone_oe)
    );

    // Clock and hang guard
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // One-cycle write strobe; settles past the taking edge
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr_reg

    // One-cycle read strobe; data sampled in the following cycle under a mask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk_byte(rdata_o & m, e);
    endtask : rd_chk

    // Instruction ticks on n consecutive cycles
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            instr_tick_i <= 1'b1;
        end
        @(posedge sys_clk_i);
        instr_tick_i <= 1'b0;
        #1;
    endtask : ticks

    // Ticking window that counts active pulse cycles and tone toggles
    task automatic run_window(input int n, input logic act);
        hits = 0;
        togs = 0;
        last = tone_out;
        repeat (n) begin
            @(posedge sys_clk_i);
            instr_tick_i <= 1'b1;
            #1;
            if (pulse_out === act) hits++;
            if (tone_out !== last) togs++;
            last = tone_out;
        end
        @(posedge sys_clk_i);
        instr_tick_i <= 1'b0;
        #1;
        if (tone_out !== last) togs++;
    endtask : run_window

    initial begin
        sys_clk_i = 1'b0;
        srst_i = 1'b1;
        instr_tick_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (5) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        // Reset values and an unmapped read
        rd_chk(dtp_pkg::ADDR_UP_MODE, 8'hFF, dtp_pkg::UP_MODE_RST);
        rd_chk(dtp_pkg::ADDR_DOWN_CTRLB, 8'hFF, dtp_pkg::CTRLB_RST);
        rd_chk(dtp_pkg::ADDR_IRQ_FLAG, 8'hFF, 8'h00);
        rd_chk(4'hF, 8'hFF, 8'h00);
        chk_bit(pulse_oe, 1'b0);
        chk_bit(tone_oe, 1'b0);
        // Up-counter load, run gate and overflow
        wr_reg(dtp_pkg::ADDR_UP_COUNT, 8'h55);
        rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h55);
        ticks(3);
        rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h55);
        wr_reg(dtp_pkg::ADDR_POWER_CTRL, 8'h01);
        ticks(3);
        rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h58);
        wr_reg(dtp_pkg::ADDR_UP_COUNT, 8'hFE);
        ticks(2);
        rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h00);
        rd_chk(dtp_pkg::ADDR_IRQ_FLAG, 8'h01, 8'h01);
        wr_reg(dtp_pkg::ADDR_IRQ_ENABLE, 8'h01);
        chk_bit(irq_o, 1'b0);
        wr_reg(dtp_pkg::ADDR_POWER_CTRL, 8'h81);
        chk_bit(irq_o, 1'b1);
        wr_reg(dtp_pkg::ADDR_IRQ_FLAG, 8'h00);
        chk_bit(irq_o, 1'b0);
        // Pin and low clock sources, both edge senses
        for (int s = 0; s < 2; s++) begin
            for (int e = 0; e < 2; e++) begin
                wr_reg(dtp_pkg::ADDR_UP_MODE, (s ? 8'hA8 : 8'h28) | (e ? 8'h10 : 8'h00));
                wr_reg(dtp_pkg::ADDR_UP_COUNT, 8'h10);
                pins.drive(s[0], 1'b1);
                rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, e ? 8'h10 : 8'h11);
                pins.drive(s[0], 1'b0);
                rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h11);
            end
        end
        // Shared prescaler ratios; a mode write clears a partial count
        for (int n = 0; n < 8; n++) begin
            ticks(1);
            wr_reg(dtp_pkg::ADDR_UP_MODE, 8'(n));
            wr_reg(dtp_pkg::ADDR_UP_COUNT, 8'h00);
            ticks((2 << n) - 1);
            rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h00);
            ticks(1);
            rd_chk(dtp_pkg::ADDR_UP_COUNT, 8'hFF, 8'h01);
        end
        // Down-counter write, run gate and count
        wr_reg(dtp_pkg::ADDR_POWER_CTRL, 8'h80);
        wr_reg(dtp_pkg::ADDR_IRQ_ENABLE, 8'h08);
        wr_reg(dtp_pkg::ADDR_HIGH_BITS, 8'h10);
        wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h05);
        rd_chk(dtp_pkg::ADDR_HIGH_BITS, 8'h30, 8'h10);
        ticks(2);
        rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, 8'h05);
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h03);
        ticks(6);
        rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, 8'hFF);
        rd_chk(dtp_pkg::ADDR_HIGH_BITS, 8'h30, 8'h00);
        // One-shot: single underflow then stop
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h00);
        wr_reg(dtp_pkg::ADDR_HIGH_BITS, 8'h00);
        wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h03);
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h05);
        ticks(3);
        rd_chk(dtp_pkg::ADDR_IRQ_FLAG, 8'h08, 8'h00);
        ticks(1);
        rd_chk(dtp_pkg::ADDR_IRQ_FLAG, 8'h08, 8'h08);
        chk_bit(irq_o, 1'b1);
        wr_reg(dtp_pkg::ADDR_IRQ_FLAG, 8'h00);
        ticks(8);
        rd_chk(dtp_pkg::ADDR_IRQ_FLAG, 8'h08, 8'h00);
        // Continuous restart from reload, then from the fixed value
        for (int r = 1; r >= 0; r--) begin
            wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h00);
            wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h03);
            wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, r ? 8'h03 : 8'h01);
            ticks(4);
            rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, r ? 8'h03 : 8'hFF);
        end
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h03);
        // Down prescaler codes 0 to 2: two decrements per window
        for (int n = 0; n < 3; n++) begin
            wr_reg(dtp_pkg::ADDR_DOWN_CTRLB, 8'(n));
            wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h10);
            ticks(4 << n);
            rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, 8'h0E);
        end
        // One more tick leaves the divide-by-8 prescaler at one
        ticks(1);
        rd_chk(dtp_pkg::ADDR_PRESC_VAL, 8'hFF, 8'h01);
        // Pin source for the down-counter, both edge senses
        for (int e = 0; e < 2; e++) begin
            wr_reg(dtp_pkg::ADDR_DOWN_CTRLB, e ? 8'h38 : 8'h28);
            wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h10);
            pins.drive(1'b0, 1'b1);
            rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, e ? 8'h10 : 8'h0F);
            pins.drive(1'b0, 1'b0);
            rd_chk(dtp_pkg::ADDR_DOWN_LOW, 8'hFF, 8'h0F);
        end
        // Pulse output: frame of four ticks, duty latched at wrap
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLB, 8'h08);
        wr_reg(dtp_pkg::ADDR_DUTY_LOW, 8'h00);
        wr_reg(dtp_pkg::ADDR_DOWN_LOW, 8'h03);
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'hC3);
        chk_bit(pulse_oe, 1'b1);
        run_window(16, 1'b0);
        chk_byte(8'(hits), 8'h00);
        wr_reg(dtp_pkg::ADDR_DUTY_LOW, 8'h02);
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk_bit(pulse_out, 1'b1);
        run_window(8, 1'b0);
        run_window(8, 1'b0);
        chk_byte(8'(hits), 8'h04);
        wr_reg(dtp_pkg::ADDR_DOWN_CTRLA, 8'h83);
        run_window(8, 1'b1);
        chk_byte(8'(hits), 8'h04);
        // Tone from underflow at two ratios, then from the prescaler
        for (int i = 0; i < 3; i++) begin
            wr_reg(dtp_pkg::ADDR_TONE_CTRL, tone_cfg[i]);
            wr_reg(dtp_pkg::ADDR_DOWN_CTRLB, ctrlb_cfg[i]);
            chk_bit(tone_oe, 1'b1);
            run_window(32, 1'b0);
            run_window(64, 1'b0);
            chk_byte(8'(togs), togs_exp[i]);
        end
        summarize();
    end
endmodule : testbench
